// ===== inc/acb_pkg.sv
// constants shared by the converter register bank
package acb_pkg;
   // ***************************************************
   // register pointer values and reset values
   // ***************************************************
   localparam logic [7:0]  ACB_PTR_RESULT  = 8'h00;
   localparam logic [7:0]  ACB_PTR_CONFIG  = 8'h01;
   localparam logic [15:0] ACB_RESULT_RST  = 16'h0000;
   localparam logic [15:0] ACB_CONFIG_RST  = 16'h8583;
   localparam logic [7:0]  ACB_PTR_RST     = 8'h00;

   // ***************************************************
   // configuration field positions
   // ***************************************************
   localparam int ACB_OS_BIT    = 15;
   localparam int ACB_MUX_LSB   = 12;
   localparam int ACB_GAIN_LSB  = 9;
   localparam int ACB_MODE_BIT  = 8;
   localparam int ACB_RATE_LSB  = 5;
   localparam int ACB_RSVD_LSB  = 0;
   localparam int ACB_RES_LSB   = 4;

   // ***************************************************
   // field codes
   // ***************************************************
   localparam logic [2:0] ACB_MUX_FIXED  = 3'h0;
   localparam logic [2:0] ACB_GAIN_FIXED = 3'h2;
   localparam logic [2:0] ACB_GAIN_LAST  = 3'h5;
   localparam logic [6:0] ACB_GCALL_ADDR = 7'h00;
   localparam logic [7:0] ACB_GCALL_RST  = 8'h06;

   // ***************************************************
   // sample rates in samples per second, and core clock
   // ***************************************************
   localparam int ACB_SPS_0  = 128;
   localparam int ACB_SPS_1  = 250;
   localparam int ACB_SPS_2  = 490;
   localparam int ACB_SPS_3  = 920;
   localparam int ACB_SPS_4  = 1600;
   localparam int ACB_SPS_5  = 2400;
   localparam int ACB_SPS_6  = 3300;
   localparam int ACB_CLK_HZ = 40_000_000;
endpackage

// ===== rtl/acb_conv_timer.sv
// conversion timing and result capture
`timescale 1ns/100ps
module acb_conv_timer #(
   parameter int CLK_HZ = acb_pkg::ACB_CLK_HZ
) (
   input  wire logic        core_clk,   // core clock
   input  wire logic        rstn,       // async reset, active low
   input  wire logic        start,      // single-shot start pulse
   input  wire logic        continuous, // continuous mode level
   input  wire logic        abort,      // soft reset pulse
   input  wire logic [2:0]  rate,       // sample rate code
   input  wire logic [11:0] sample_in,  // modulator output word
   output logic             busy,       // conversion running
   output logic             done,       // one-cycle end pulse
   output logic [11:0]      result      // latest result
);
   import acb_pkg::*;

   logic [23:0] cnt_q;
   logic        busy_q;
   logic        done_q;
   logic [11:0] result_q;
   logic        last;

   // cycles of one conversion for a rate code
   function automatic logic [23:0] rate_cycles(input logic [2:0] c);
      logic [23:0] n;
      n = 24'(CLK_HZ / ACB_SPS_6);
      case (c)
         3'h0: n = 24'(CLK_HZ / ACB_SPS_0);
         3'h1: n = 24'(CLK_HZ / ACB_SPS_1);
         3'h2: n = 24'(CLK_HZ / ACB_SPS_2);
         3'h3: n = 24'(CLK_HZ / ACB_SPS_3);
         3'h4: n = 24'(CLK_HZ / ACB_SPS_4);
         3'h5: n = 24'(CLK_HZ / ACB_SPS_5);
         default: n = 24'(CLK_HZ / ACB_SPS_6);
      endcase
      return n;
   endfunction

   assign last = busy_q && (cnt_q <= 24'h000001);

   // run counter; continuous mode reloads at each end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         cnt_q  <= 24'h000000;
      end else if (abort) begin
         busy_q <= 1'b0;
         cnt_q  <= 24'h000000;
      end else if (!busy_q && (start || continuous)) begin
         busy_q <= 1'b1;
         cnt_q  <= rate_cycles(rate);
      end else if (last) begin
         busy_q <= continuous;
         cnt_q  <= rate_cycles(rate);
      end else if (busy_q) begin
         cnt_q  <= cnt_q - 24'h000001;
      end
   end

   // result stays zero until the first conversion ends
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         result_q <= 12'h000;
         done_q   <= 1'b0;
      end else if (abort) begin
         result_q <= 12'h000;
         done_q   <= 1'b0;
      end else begin
         done_q <= last;
         if (last)
            result_q <= sample_in;
      end
   end

   assign busy   = busy_q;
   assign done   = done_q;
   assign result = result_q;
endmodule

// ===== rtl/acb_reg_bank.sv
// converter register bank behind a two-wire serial target port
`timescale 1ns/100ps
module acb_reg_bank #(
   parameter logic [6:0] DEV_ADDR = 7'h48,  // target address
   parameter bit         HAS_MUX  = 1'b1,   // input multiplexer fitted
   parameter bit         HAS_GAIN = 1'b1,   // gain stage fitted
   parameter int         CLK_HZ   = acb_pkg::ACB_CLK_HZ
) (
   input  wire logic        core_clk,        // core clock
   input  wire logic        rstn,            // async reset, active low
   input  wire logic        scl,             // serial clock pin
   input  wire logic        sda_in,          // serial data pin level
   output logic             sda_out,         // serial data drive value
   output logic             sda_oe,          // serial data drive enable
   input  wire logic [11:0] sample_in,       // modulator result word
   output logic [1:0]       analog_pos_sel,  // positive input number
   output logic [1:0]       analog_neg_sel,  // negative input number
   output logic             analog_neg_gnd,  // negative input is ground
   output logic [2:0]       gain_range_select, // span code
   output logic [2:0]       sample_rate_select, // rate code
   output logic             conv_busy        // conversion running
);
   import acb_pkg::*;

   typedef enum {ACB_IDLE, ACB_ADDR, ACB_WRITE, ACB_ACK_PEND, ACB_ACK,
                 ACB_READ, ACB_MACK, ACB_SKIP} acb_state_t;

   // ***************************************************
   // pin synchronisers and bus conditions
   // ***************************************************
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic scl_rise, scl_fall, start_det, stop_det;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
      end else begin
         scl_s1 <= scl;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   assign scl_rise  = scl_s2 & ~scl_d;
   assign scl_fall  = ~scl_s2 & scl_d;
   assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

   // ***************************************************
   // serial engine
   // ***************************************************
   acb_state_t  state_q;
   logic [2:0]  bit_q;
   logic [7:0]  rx_q, tx_q;
   logic [7:0]  rx_byte;
   logic        rd_q, gcall_q, mack_q, lsb_q, ack_drv_q;
   logic [1:0]  idx_q;
   logic        byte_stb_q;
   logic [7:0]  byte_q;
   logic [1:0]  byte_idx_q;
   logic [15:0] rd_word;
   logic [7:0]  ptr_q;
   logic [15:0] cfg_rd, res_rd;

   assign rx_byte = {rx_q[6:0], sda_s2};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q    <= ACB_IDLE;
         bit_q      <= 3'h0;
         rx_q       <= 8'h00;
         tx_q       <= 8'h00;
         rd_q       <= 1'b0;
         gcall_q    <= 1'b0;
         mack_q     <= 1'b0;
         lsb_q      <= 1'b0;
         ack_drv_q  <= 1'b0;
         idx_q      <= 2'h0;
         byte_stb_q <= 1'b0;
         byte_q     <= 8'h00;
         byte_idx_q <= 2'h0;
      end else begin
         byte_stb_q <= 1'b0;
         if (start_det) begin
            state_q   <= ACB_ADDR;
            bit_q     <= 3'h0;
            ack_drv_q <= 1'b0;
         end else if (stop_det) begin
            state_q   <= ACB_IDLE;
            ack_drv_q <= 1'b0;
         end else begin
            case (state_q)
               ACB_ADDR, ACB_WRITE: begin
                  if (scl_rise) begin
                     rx_q  <= rx_byte;
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == 3'h7 && state_q == ACB_ADDR) begin
                        rd_q    <= sda_s2;
                        gcall_q <= (rx_q[6:0] == ACB_GCALL_ADDR);
                        idx_q   <= 2'h0;
                        lsb_q   <= 1'b0;
                        if (rx_q[6:0] == DEV_ADDR ||
                            (rx_q[6:0] == ACB_GCALL_ADDR && !sda_s2))
                           state_q <= ACB_ACK_PEND;
                        else
                           state_q <= ACB_SKIP;
                     end else if (bit_q == 3'h7) begin
                        byte_stb_q <= 1'b1;
                        byte_q     <= rx_byte;
                        byte_idx_q <= idx_q;
                        if (idx_q != 2'h3)
                           idx_q <= idx_q + 2'h1;
                        state_q <= ACB_ACK_PEND;
                     end
                  end
               end
               ACB_ACK_PEND: begin
                  if (scl_fall) begin
                     ack_drv_q <= 1'b1;
                     state_q   <= ACB_ACK;
                  end
               end
               ACB_ACK: begin
                  if (scl_fall) begin
                     ack_drv_q <= 1'b0;
                     bit_q     <= 3'h0;
                     if (rd_q) begin
                        tx_q    <= rd_word[15:8];
                        lsb_q   <= 1'b1;
                        state_q <= ACB_READ;
                     end else begin
                        state_q <= ACB_WRITE;
                     end
                  end
               end
               ACB_READ: begin
                  if (scl_fall) begin
                     if (bit_q == 3'h7) begin
                        state_q <= ACB_MACK;
                     end else begin
                        tx_q  <= {tx_q[6:0], 1'b0};
                        bit_q <= bit_q + 3'h1;
                     end
                  end
               end
               ACB_MACK: begin
                  if (scl_rise)
                     mack_q <= ~sda_s2;
                  if (scl_fall) begin
                     bit_q <= 3'h0;
                     if (mack_q) begin
                        tx_q    <= lsb_q ? rd_word[7:0] : rd_word[15:8];
                        lsb_q   <= ~lsb_q;
                        state_q <= ACB_READ;
                     end else begin
                        state_q <= ACB_SKIP;
                     end
                  end
               end
               ACB_SKIP: state_q <= ACB_SKIP;
               default:  state_q <= ACB_IDLE;
            endcase
         end
      end
   end

   // open-drain data; the clock line has no driver at all
   assign sda_out = 1'b0;
   assign sda_oe  = ack_drv_q | ((state_q == ACB_READ) & ~tx_q[7]);

   // ***************************************************
   // pointer and configuration registers
   // ***************************************************
   logic       os_wr_q;
   logic [2:0] mux_q, gain_q, rate_q;
   logic       mode_q;
   logic [4:0] rsvd_q;
   logic [7:0] msb_q;
   logic       soft_rst_q, start_q;
   logic       busy;
   logic [11:0] result;
   logic [15:0] cfg_wr;

   assign cfg_wr = {msb_q, byte_q};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ptr_q      <= ACB_PTR_RST;
         msb_q      <= 8'h00;
         mux_q      <= ACB_CONFIG_RST[ACB_MUX_LSB +: 3];
         gain_q     <= ACB_CONFIG_RST[ACB_GAIN_LSB +: 3];
         mode_q     <= ACB_CONFIG_RST[ACB_MODE_BIT];
         rate_q     <= ACB_CONFIG_RST[ACB_RATE_LSB +: 3];
         rsvd_q     <= ACB_CONFIG_RST[ACB_RSVD_LSB +: 5];
         soft_rst_q <= 1'b0;
         start_q    <= 1'b0;
      end else begin
         soft_rst_q <= 1'b0;
         start_q    <= 1'b0;
         if (byte_stb_q && gcall_q) begin
            if (byte_idx_q == 2'h0 && byte_q == ACB_GCALL_RST)
               soft_rst_q <= 1'b1;
         end else if (byte_stb_q) begin
            case (byte_idx_q)
               2'h0: ptr_q <= byte_q;
               2'h1: msb_q <= byte_q;
               2'h2: begin
                  if (ptr_q == ACB_PTR_CONFIG) begin
                     mux_q  <= HAS_MUX ? cfg_wr[ACB_MUX_LSB +: 3]
                                       : ACB_MUX_FIXED;
                     gain_q <= HAS_GAIN ? cfg_wr[ACB_GAIN_LSB +: 3]
                                        : ACB_GAIN_FIXED;
                     mode_q <= cfg_wr[ACB_MODE_BIT];
                     rate_q <= cfg_wr[ACB_RATE_LSB +: 3];
                     rsvd_q <= cfg_wr[ACB_RSVD_LSB +: 5];
                     start_q <= cfg_wr[ACB_OS_BIT] &
                                cfg_wr[ACB_MODE_BIT] & ~busy;
                  end
               end
               default: ptr_q <= ptr_q;
            endcase
         end
         if (soft_rst_q) begin
            ptr_q  <= ACB_PTR_RST;
            mux_q  <= ACB_CONFIG_RST[ACB_MUX_LSB +: 3];
            gain_q <= ACB_CONFIG_RST[ACB_GAIN_LSB +: 3];
            mode_q <= ACB_CONFIG_RST[ACB_MODE_BIT];
            rate_q <= ACB_CONFIG_RST[ACB_RATE_LSB +: 3];
            rsvd_q <= ACB_CONFIG_RST[ACB_RSVD_LSB +: 5];
         end
      end
   end

   // conversion timing; mode bit low runs back to back
   acb_conv_timer #(
      .CLK_HZ     (CLK_HZ)
   ) u_conv (
      .core_clk   (core_clk),
      .rstn       (rstn),
      .start      (start_q),
      .continuous (~mode_q),
      .abort      (soft_rst_q),
      .rate       (rate_q),
      .sample_in  (sample_in),
      .busy       (busy),
      .done       (),
      .result     (result)
   );

   // ***************************************************
   // read data and decoded analog controls
   // ***************************************************
   always_comb begin
      cfg_rd = {1'b0, mux_q, gain_q, mode_q, rate_q, rsvd_q};
      cfg_rd[ACB_OS_BIT] = mode_q & ~busy;
      res_rd = {result, 4'h0};
      case (ptr_q)
         ACB_PTR_RESULT: rd_word = res_rd;
         ACB_PTR_CONFIG: rd_word = cfg_rd;
         default:        rd_word = 16'h0000;
      endcase
   end

   // input pair, span and rate presented to the analog side
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         analog_pos_sel     <= 2'h0;
         analog_neg_sel     <= 2'h1;
         analog_neg_gnd     <= 1'b0;
         gain_range_select  <= ACB_GAIN_FIXED;
         sample_rate_select <= ACB_CONFIG_RST[ACB_RATE_LSB +: 3];
      end else begin
         analog_neg_gnd <= mux_q[2];
         case (mux_q)
            3'h0: {analog_pos_sel, analog_neg_sel} <= 4'h1;
            3'h1: {analog_pos_sel, analog_neg_sel} <= 4'h3;
            3'h2: {analog_pos_sel, analog_neg_sel} <= 4'h7;
            3'h3: {analog_pos_sel, analog_neg_sel} <= 4'hb;
            default: {analog_pos_sel, analog_neg_sel} <= {mux_q[1:0], 2'h0};
         endcase
         gain_range_select  <= (gain_q > ACB_GAIN_LAST) ? ACB_GAIN_LAST
                                                         : gain_q;
         sample_rate_select <= rate_q;
      end
   end

   assign conv_busy = busy;
endmodule

// ===== verif/acb_reg_bank_assertions.sv
// port checker for the converter register bank
`timescale 1ns/100ps
module acb_reg_bank_chk
   import acb_pkg::*;
#(
   parameter int CLK_HZ = ACB_CLK_HZ
) (
   input wire logic        core_clk,           // core clock
   input wire logic        rstn,               // async reset, active low
   input wire logic        scl,                // serial clock pin
   input wire logic        sda_in,             // serial data level
   input wire logic        sda_out,            // serial data drive value
   input wire logic        sda_oe,             // serial data drive enable
   input wire logic [11:0] sample_in,          // modulator word
   input wire logic [1:0]  analog_pos_sel,     // positive input
   input wire logic [1:0]  analog_neg_sel,     // negative input
   input wire logic        analog_neg_gnd,     // negative is ground
   input wire logic [2:0]  gain_range_select,  // span code
   input wire logic [2:0]  sample_rate_select, // rate code
   input wire logic        conv_busy           // conversion running
);
   int unsigned busy_cnt_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // ***************************************************
   // helpers
   // ***************************************************
   // expected conversion length in core cycles
   function automatic int conv_len(logic [2:0] r);
      case (r)
         3'h0: return CLK_HZ / ACB_SPS_0;
         3'h1: return CLK_HZ / ACB_SPS_1;
         3'h2: return CLK_HZ / ACB_SPS_2;
         3'h3: return CLK_HZ / ACB_SPS_3;
         3'h4: return CLK_HZ / ACB_SPS_4;
         3'h5: return CLK_HZ / ACB_SPS_5;
         default: return CLK_HZ / ACB_SPS_6;
      endcase
   endfunction

   // length of the current busy run
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) busy_cnt_q <= 0;
      else if (conv_busy) busy_cnt_q <= busy_cnt_q + 1;
      else busy_cnt_q <= 0;
   end

   // ***************************************************
   // properties
   // ***************************************************
   sequence s_conv_start;
      $rose(conv_busy);
   endsequence
   sequence s_ack_near;
      ##[0:20] sda_oe;
   endsequence

   property p_reset_vals;
      $rose(rstn) |-> !sda_oe && !conv_busy && gain_range_select == 3'h2
         && sample_rate_select == 3'h4 && analog_pos_sel == 2'h0
         && analog_neg_sel == 2'h1 && !analog_neg_gnd;
   endproperty
   property p_start_ack;
      s_conv_start |-> s_ack_near;
   endproperty
   property p_busy_hold;
      s_conv_start |-> conv_busy [*8];
   endproperty
   property p_busy_len;
      $fell(conv_busy) |->
         ((busy_cnt_q + 1) % conv_len(sample_rate_select)) <= 2;
   endproperty
   property p_mux_pairs;
      !analog_neg_gnd |-> (analog_pos_sel == 2'h0 && analog_neg_sel == 2'h1)
         || (analog_neg_sel == 2'h3 && analog_pos_sel != 2'h3);
   endproperty
   property p_gain_clamp;
      gain_range_select <= ACB_GAIN_LAST;
   endproperty
   property p_drive_low_only;
      sda_out == 1'b0;
   endproperty
   property p_oe_moves_scl_low;
      $changed(sda_oe) |-> !scl;
   endproperty

   a_reset_vals: assert property (p_reset_vals)
      else $error("outputs not at reset values");
   a_start_ack: assert property (p_start_ack)
      else $error("conversion began outside a write");
   a_busy_hold: assert property (p_busy_hold)
      else $error("conversion ended at once");
   a_busy_len: assert property (p_busy_len)
      else $error("conversion length off rate");
   a_mux_pairs: assert property (p_mux_pairs)
      else $error("illegal input pair");
   a_gain_clamp: assert property (p_gain_clamp)
      else $error("span code above clamp");
   a_drive_low_only: assert property (p_drive_low_only)
      else $error("data line driven high");
   a_oe_moves_scl_low: assert property (p_oe_moves_scl_low)
      else $error("data changed with clock high");
endmodule

bind acb_reg_bank acb_reg_bank_chk #(.CLK_HZ(CLK_HZ)) u_chk (
   .core_clk(core_clk), .rstn(rstn), .scl(scl), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .sample_in(sample_in),
   .analog_pos_sel(analog_pos_sel), .analog_neg_sel(analog_neg_sel),
   .analog_neg_gnd(analog_neg_gnd), .gain_range_select(gain_range_select),
   .sample_rate_select(sample_rate_select), .conv_busy(conv_busy));

// ===== verif/acb_i2c_host.sv
// two-wire serial host model driving the register bank
`timescale 1ns/100ps
module acb_i2c_host #(
   parameter logic [6:0] ADDR = 7'h48
) (
   input wire logic core_clk, // core clock
   input wire logic sda,      // resolved data line
   output logic     scl,      // serial clock, idles high
   output logic     sda_low   // high pulls the data line low
);
   int nacks;

   // bus idle, clock stands still outside frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      nacks = 0;
   end

   task automatic w(int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one bit: low 5 cycles, high 3, sample in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_low <= ~b;
      w(4);
      scl <= 1'b1;
      w(2);
      r = sda;
      w(1);
      scl <= 1'b0;
      w(1);
   endtask
   // start or repeated start
   // clock stays low five cycles, as in a data bit, so the target's
   // ack release lands before the clock rises again
   task automatic start();
      sda_low <= 1'b0;
      w(4);
      scl <= 1'b1;
      w(2);
      sda_low <= 1'b1;
      w(2);
      scl <= 1'b0;
      w(1);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      w(4);
      scl <= 1'b1;
      w(2);
      sda_low <= 1'b0;
      w(4);
   endtask
   // byte out, msb first, count missing acks
   task automatic wbyte(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      if (r !== 1'b0) nacks++;
   endtask
   // byte in, then ack or nack
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
   // pointer then both data bytes, msb first
   task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] data);
      start();
      wbyte({ADDR, 1'b0});
      wbyte(ptr);
      wbyte(data[15:8]);
      wbyte(data[7:0]);
      stop();
   endtask
   // read, optionally setting the pointer first
   task automatic rd_reg(input logic setp, input logic [7:0] ptr,
                         output logic [15:0] d);
      if (setp) begin
         start();
         wbyte({ADDR, 1'b0});
         wbyte(ptr);
      end
      start();
      wbyte({ADDR, 1'b1});
      rbyte(1'b0, d[15:8]);
      rbyte(1'b1, d[7:0]);
      stop();
   endtask
   // general call followed by the reset byte
   task automatic gcall();
      start();
      wbyte({acb_pkg::ACB_GCALL_ADDR, 1'b0});
      wbyte(acb_pkg::ACB_GCALL_RST);
      stop();
   endtask
endmodule

// ===== verif/acb_reg_bank_bench.sv
// self-checking bench for the converter register bank
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("Error %s expected %h seen %h", nm, exp, got); \
      end \
   end
module acb_reg_bank_bench;
   import acb_pkg::*;
   logic        core_clk;
   logic        rstn;
   logic [11:0] sample_in;
   logic        scl;
   logic        sda_low;
   logic        sda_oe;
   logic        sda_out;
   logic [1:0]  pos_sel;
   logic [1:0]  neg_sel;
   logic        neg_gnd;
   logic [2:0]  gain;
   logic [2:0]  rate;
   logic        conv_busy;
   wire         sda_line = ~(sda_oe | sda_low); // pull-up
   logic [15:0] d;
   logic [15:0] cfg;
   logic [2:0]  c;
   int          num_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;

   acb_reg_bank #(.CLK_HZ(400_000)) dut (
      .core_clk(core_clk), .rstn(rstn), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .sample_in(sample_in),
      .analog_pos_sel(pos_sel), .analog_neg_sel(neg_sel),
      .analog_neg_gnd(neg_gnd), .gain_range_select(gain),
      .sample_rate_select(rate), .conv_busy(conv_busy));
   acb_i2c_host host (.core_clk(core_clk), .sda(sda_line), .scl(scl),
                      .sda_low(sda_low));

   // ***************************************************
   // clock, timeout and closing
   // ***************************************************
   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;
   // cut a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // bounded wait for the conversion to finish
   task automatic wait_idle();
      for (int n = 0; n < 5000 && conv_busy !== 1'b0; n++)
         @(posedge core_clk);
      `CHK("idle", 1'b0, conv_busy)
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      rstn <= 1'b0;
      sample_in <= 12'h000;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      host.rd_reg(1'b1, ACB_PTR_RESULT, d);
      `CHK("result_rst", ACB_RESULT_RST, d)
      host.rd_reg(1'b0, ACB_PTR_RESULT, d);
      `CHK("result_again", ACB_RESULT_RST, d)
      host.rd_reg(1'b1, ACB_PTR_CONFIG, d);
      `CHK("config_rst", ACB_CONFIG_RST, d)
      $display("test reset values done");
      // single shot at the slowest rate
      sample_in <= 12'ha5c;
      host.wr_reg(ACB_PTR_CONFIG, 16'h8503);
      `CHK("busy", 1'b1, conv_busy)
      host.rd_reg(1'b0, ACB_PTR_CONFIG, d);
      `CHK("status_busy", 16'h0503, d)
      // a second start while busy must not restart the run
      host.wr_reg(ACB_PTR_CONFIG, 16'h8503);
      `CHK("busy_again", 1'b1, conv_busy)
      wait_idle();
      host.rd_reg(1'b0, ACB_PTR_CONFIG, d);
      `CHK("status_idle", 16'h8503, d)
      host.rd_reg(1'b1, ACB_PTR_RESULT, d);
      `CHK("result", 16'ha5c0, d)
      `CHK("result_low", 4'h0, d[3:0])
      host.wr_reg(ACB_PTR_CONFIG, 16'h0503);
      `CHK("no_start", 1'b0, conv_busy)
      $display("test single shot done");
      // every code of the select fields
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         cfg = {1'b0, c, c, 1'b1, c, 5'h03};
         host.wr_reg(ACB_PTR_CONFIG, cfg);
         `CHK("neg_gnd", c[2], neg_gnd)
         if (c[2]) `CHK("pos_gnd", c[1:0], pos_sel)
         else `CHK("pos", (c == 3'h0) ? 2'h0 : 2'(c - 3'h1), pos_sel)
         if (!c[2]) `CHK("neg", (c == 3'h0) ? 2'h1 : 2'h3, neg_sel)
         `CHK("gain", (c > 3'h5) ? 3'h5 : c, gain)
         `CHK("rate", c, rate)
      end
      host.rd_reg(1'b1, ACB_PTR_CONFIG, d);
      `CHK("config_back", {1'b1, cfg[14:0]}, d)
      $display("test field codes done");
      // continuous mode, then back to single shot
      sample_in <= 12'h3c1;
      host.wr_reg(ACB_PTR_CONFIG, 16'h04c3);
      `CHK("cont_busy", 1'b1, conv_busy)
      host.rd_reg(1'b0, ACB_PTR_CONFIG, d);
      `CHK("cont_status", 16'h04c3, d)
      host.wr_reg(ACB_PTR_CONFIG, 16'h05c3);
      wait_idle();
      host.rd_reg(1'b1, ACB_PTR_RESULT, d);
      `CHK("cont_result", 16'h3c10, d)
      $display("test continuous done");
      // software reset through the general call
      host.gcall();
      host.rd_reg(1'b1, ACB_PTR_CONFIG, d);
      `CHK("soft_cfg", ACB_CONFIG_RST, d)
      `CHK("soft_gain", 3'h2, gain)
      host.rd_reg(1'b1, ACB_PTR_RESULT, d);
      `CHK("soft_result", ACB_RESULT_RST, d)
      `CHK("nacks", 0, host.nacks)
      $display("test soft reset done");
      test_done();
   end
endmodule
